/* hdl/lgec_pkg.sv */
package lgec_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing: blink timebase derived from the system clock
   localparam int MCLK_HZ       = 20_000_000;                                  // system clock rate
   localparam int BLINK_BASE_HZ = 152;                                         // fastest blink rate
   localparam int BLINK_STEPS   = 256;                                         // duty counter steps
   // clocks per duty step, rounded rather than floored: one clock short is about a fifth of a percent of blink rate
   localparam int TICK_CYCLES   = (MCLK_HZ + BLINK_BASE_HZ * BLINK_STEPS / 2) / (BLINK_BASE_HZ * BLINK_STEPS);
   localparam int TICK_W        = $clog2(TICK_CYCLES);

   ////////////////////////////////////////////////////////////////////////////
   // register pointer values
   localparam logic [3:0] PTR_INPUT_LOW    = 4'h0;
   localparam logic [3:0] PTR_INPUT_HIGH   = 4'h1;
   localparam logic [3:0] PTR_PRESCALE_0   = 4'h2;
   localparam logic [3:0] PTR_DUTY_0       = 4'h3;
   localparam logic [3:0] PTR_PRESCALE_1   = 4'h4;
   localparam logic [3:0] PTR_DUTY_1       = 4'h5;
   localparam logic [3:0] PTR_SEL_0_3      = 4'h6;
   localparam logic [3:0] PTR_SEL_4_7      = 4'h7;
   localparam logic [3:0] PTR_SEL_8_11     = 4'h8;
   localparam logic [3:0] PTR_SEL_12_15    = 4'h9;
   localparam logic [3:0] PTR_LAST         = 4'h9;

   ////////////////////////////////////////////////////////////////////////////
   // command byte and slave address layout
   localparam int         CMD_AI_BIT       = 4;                                // auto_increment flag position
   localparam int         CMD_PTR_LSB      = 0;                                // pointer nibble position
   localparam logic [3:0] ADDR_FIXED       = 4'hC;                             // upper four address bits

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] PRESCALE_RESET   = 8'h00;
   localparam logic [7:0] DUTY_RESET       = 8'h80;
   localparam logic [7:0] SEL_RESET        = 8'h00;
   localparam logic [3:0] PTR_RESET        = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // led_pin_selector codes
   localparam logic [1:0] SEL_RELEASED     = 2'h0;
   localparam logic [1:0] SEL_DRIVE_LOW    = 2'h1;
   localparam logic [1:0] SEL_BLINK_FIRST  = 2'h2;
   localparam logic [1:0] SEL_BLINK_SECOND = 2'h3;

   localparam int NUM_PINS     = 16;
   localparam int PINS_PER_SEL = 4;
   localparam int NUM_SEL      = 4;
   localparam int NUM_BLINK    = 2;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_WDATA,
      ST_ACK,
      ST_RDATA,
      ST_MACK
   } lgec_bus_state_t;

   typedef struct packed {
      logic [7:0] prescale;                                                    // period = (prescale+1)/152 s
      logic [7:0] duty;                                                        // low time = duty/256
   } lgec_blink_cfg_t;

   typedef struct packed {
      logic [7:0] pre_cnt;
      logic [7:0] step_cnt;
      logic       active;
   } lgec_blink_state_t;

   typedef struct packed {
      lgec_bus_state_t                 bus;
      logic                            scl_q;
      logic                            sda_q;
      logic [7:0]                      shift;
      logic [3:0]                      bit_cnt;
      logic                            rw;
      logic                            cmd_seen;
      logic                            mack;
      logic [3:0]                      ptr;
      logic                            ai;
      lgec_blink_cfg_t [NUM_BLINK-1:0] blink;
      logic [NUM_SEL-1:0][7:0]         sel;
      logic [NUM_BLINK-1:0]            restart;
      logic [TICK_W-1:0]               tick_cnt;
      logic                            tick;
      logic                            sda_oe;
      logic [NUM_PINS-1:0]             pin_oe;
   } lgec_state_t;

endpackage : lgec_pkg

/* hdl/lgec_blink_channel.sv */
`timescale 1ns/10ps
module lgec_blink_channel
   import lgec_pkg::*;
(
   input  wire logic      mclk,        // system clock
   input  wire logic      rst_n,       // combined async reset, low active
   input  wire logic      tick,        // one duty step of the timebase
   input  wire logic      restart,     // duty written, restart the count
   input  lgec_blink_cfg_t cfg,        // prescale and duty
   output logic           active       // high while pins must be pulled low
);

   lgec_blink_state_t state;
   lgec_blink_state_t next_state;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler stretches each duty step by prescale+1 ticks
   always_comb begin
      next_state = state;
      if (restart) begin
         next_state.pre_cnt  = 8'h00;
         next_state.step_cnt = 8'h00;
      end else if (tick) begin
         if (state.pre_cnt >= cfg.prescale) begin
            next_state.pre_cnt  = 8'h00;
            next_state.step_cnt = state.step_cnt + 8'h01;
         end else begin
            next_state.pre_cnt = state.pre_cnt + 8'h01;
         end
      end
      // a duty of zero never drives, and with duty at most 255 the top step is always released
      next_state.active = (next_state.step_cnt < cfg.duty);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '{pre_cnt: 8'h00, step_cnt: 8'h00, active: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign active = state.active;

endmodule : lgec_blink_channel

/* hdl/lgec_expander.sv */
`timescale 1ns/10ps
// Function
// - Pin levels are readable through pin_input_low and pin_input_high.
// - Released selector code leaves the open-drain output undriven.
// - Drive-low selector code drives the pin low continuously.
// - Reset pin low returns registers and serial state machine to defaults.
// - Logic held in reset while supply stays below power-on threshold.
// - Supply rising past threshold releases reset with defaults loaded.
// - Answers slave address C0h with address-select pins low.
// - Command 12h sets auto_increment, pointer at blink_prescaler_0, then sequence.
// - Writing 55h to first selector drives pins 0 to 3 low.
// - Writing FFh to third selector blinks pins 8 to 11 on second channel.
// - Prescaler zero gives first channel 152 Hz blink.
// - Code 10 blinks with first channel, code 11 with second.
// - Blink period equals prescaler plus one, divided by 152, seconds.
// - 8-bit counter 0..255 drives low while below duty value.
// - With auto_increment the pointer advances and wraps to zero after last selector.
module lgec_expander
   import lgec_pkg::*;
(
   input  wire logic                mclk,             // 20 MHz system clock
   input  wire logic                reset_n,          // external reset pin, low active
   input  wire logic                supply_ok,        // power-on detector, low while supply is short
   input  wire logic                addr_select_bit0, // address-select pin 0
   input  wire logic                addr_select_bit1, // address-select pin 1
   input  wire logic                addr_select_bit2, // address-select pin 2
   input  wire logic                scl_in,           // serial clock level
   input  wire logic                sda_in,           // serial data level
   output logic                     sda_out,          // serial data drive value, always low
   output logic                     sda_oe,           // serial data pulled low when high
   input  wire logic [NUM_PINS-1:0] pin_in,           // pin levels
   output logic [NUM_PINS-1:0]      pin_out,          // pin drive values, always low
   output logic [NUM_PINS-1:0]      pin_oe            // pin pulled low when high
);

   localparam lgec_state_t STATE_RESET = '{
      bus:      ST_IDLE,
      scl_q:    1'b1,
      sda_q:    1'b1,
      shift:    8'h00,
      bit_cnt:  4'h0,
      rw:       1'b0,
      cmd_seen: 1'b0,
      mack:     1'b0,
      ptr:      PTR_RESET,
      ai:       1'b0,
      blink:    {NUM_BLINK{PRESCALE_RESET, DUTY_RESET}},
      sel:      {NUM_SEL{SEL_RESET}},
      restart:  2'h0,
      tick_cnt: '0,
      tick:     1'b0,
      sda_oe:   1'b0,
      pin_oe:   16'h0000
   };

   lgec_state_t            s;
   lgec_state_t            n;
   logic                   rst_n;
   logic [NUM_BLINK-1:0]   blink_active;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // pointer step; without auto_increment the pointer stays put
   function automatic logic [3:0] next_ptr(input logic [3:0] ptr, input logic ai);
      logic [3:0] res;
      res = ptr;
      if (ai) begin
         if (ptr >= PTR_LAST) begin
            res = 4'h0;
         end else begin
            res = ptr + 4'h1;
         end
      end
      return res;
   endfunction : next_ptr

   // read data for a pointer; unmapped pointers read as zero
   function automatic logic [7:0] reg_read(input logic [3:0] ptr, input logic [NUM_PINS-1:0] pins,
                                           input lgec_state_t st);
      logic [7:0] res;
      res = 8'h00;
      case (ptr)
         PTR_INPUT_LOW:  res = pins[7:0];
         PTR_INPUT_HIGH: res = pins[15:8];
         PTR_PRESCALE_0: res = st.blink[0].prescale;
         PTR_DUTY_0:     res = st.blink[0].duty;
         PTR_PRESCALE_1: res = st.blink[1].prescale;
         PTR_DUTY_1:     res = st.blink[1].duty;
         PTR_SEL_0_3:    res = st.sel[0];
         PTR_SEL_4_7:    res = st.sel[1];
         PTR_SEL_8_11:   res = st.sel[2];
         PTR_SEL_12_15:  res = st.sel[3];
         default:        res = 8'h00;
      endcase
      return res;
   endfunction : reg_read

   // selector code to pull-low decision
   function automatic logic drive_low(input logic [1:0] code, input logic [NUM_BLINK-1:0] blink);
      logic res;
      res = 1'b0;
      case (code)
         SEL_RELEASED:     res = 1'b0;
         SEL_DRIVE_LOW:    res = 1'b1;
         SEL_BLINK_FIRST:  res = blink[0];
         SEL_BLINK_SECOND: res = blink[1];
         default:          res = 1'b0;
      endcase
      return res;
   endfunction : drive_low

   ////////////////////////////////////////////////////////////////////////////
   // reset: pin and power-on detector both hold everything in reset
   assign rst_n = reset_n & supply_ok;

   ////////////////////////////////////////////////////////////////////////////
   // next state: timebase, serial engine, register writes, pin drive
   always_comb begin
      logic       scl_rise;
      logic       scl_fall;
      logic       start_cond;
      logic       stop_cond;
      logic [7:0] rdata;
      logic [1:0] code;
      scl_rise   = ~s.scl_q & scl_in;
      scl_fall   = s.scl_q & ~scl_in;
      start_cond = s.scl_q & scl_in & s.sda_q & ~sda_in;
      stop_cond  = s.scl_q & scl_in & ~s.sda_q & sda_in;
      rdata      = reg_read(s.ptr, pin_in, s);
      code       = 2'h0;

      n         = s;
      n.scl_q   = scl_in;
      n.sda_q   = sda_in;
      n.tick    = 1'b0;
      n.restart = 2'h0;

      // duty step timebase; 514 clocks trade a fraction of a percent in rate for no fractional divider
      if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
         n.tick_cnt = '0;
         n.tick     = 1'b1;
      end else begin
         n.tick_cnt = s.tick_cnt + 1'b1;
      end

      // start and stop win over any bit activity, even mid-byte
      if (start_cond) begin
         n.bus      = ST_ADDR;
         n.bit_cnt  = 4'h0;
         n.sda_oe   = 1'b0;
         n.cmd_seen = 1'b0;
         n.mack     = 1'b0;
      end else if (stop_cond) begin
         n.bus    = ST_IDLE;
         n.sda_oe = 1'b0;
         n.mack   = 1'b0;
      end else begin
         case (s.bus)
            ST_IDLE: begin
               n.sda_oe = 1'b0;
            end
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (scl_rise) begin
                  n.shift   = {s.shift[6:0], sda_in};
                  n.bit_cnt = s.bit_cnt + 4'h1;
               end else if (scl_fall && s.bit_cnt == 4'h8) begin
                  // acknowledge is driven from this fall to the next
                  n.bit_cnt = 4'h0;
                  n.bus     = ST_ACK;
                  n.sda_oe  = 1'b1;
                  case (s.bus)
                     ST_ADDR: begin
                        if (s.shift[7:1] == {ADDR_FIXED, addr_select_bit2, addr_select_bit1,
                                             addr_select_bit0}) begin
                           n.rw = s.shift[0];
                        end else begin
                           n.bus    = ST_IDLE;
                           n.sda_oe = 1'b0;
                        end
                     end
                     ST_CMD: begin
                        n.ptr      = s.shift[CMD_PTR_LSB +: 4];
                        n.ai       = s.shift[CMD_AI_BIT];
                        n.cmd_seen = 1'b1;
                     end
                     default: begin
                        // input registers and unmapped pointers are acked but ignored
                        case (s.ptr)
                           PTR_PRESCALE_0: n.blink[0].prescale = s.shift;
                           PTR_DUTY_0: begin
                              n.blink[0].duty = s.shift;
                              n.restart[0]    = 1'b1;
                           end
                           PTR_PRESCALE_1: n.blink[1].prescale = s.shift;
                           PTR_DUTY_1: begin
                              n.blink[1].duty = s.shift;
                              n.restart[1]    = 1'b1;
                           end
                           PTR_SEL_0_3:   n.sel[0] = s.shift;
                           PTR_SEL_4_7:   n.sel[1] = s.shift;
                           PTR_SEL_8_11:  n.sel[2] = s.shift;
                           PTR_SEL_12_15: n.sel[3] = s.shift;
                           default:       n.sel    = s.sel;
                        endcase
                        n.ptr = next_ptr(s.ptr, s.ai);
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  n.bit_cnt = 4'h0;
                  if (s.rw) begin
                     // input levels are captured at this fall
                     n.bus    = ST_RDATA;
                     n.shift  = rdata;
                     n.sda_oe = ~rdata[7];
                  end else begin
                     n.bus    = s.cmd_seen ? ST_WDATA : ST_CMD;
                     n.sda_oe = 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  n.bit_cnt = s.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (s.bit_cnt == 4'h8) begin
                     n.bus     = ST_MACK;
                     n.bit_cnt = 4'h0;
                     n.sda_oe  = 1'b0;
                  end else begin
                     n.shift  = {s.shift[6:0], 1'b0};
                     n.sda_oe = ~s.shift[6];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  if (!sda_in) begin
                     n.mack = 1'b1;
                     n.ptr  = next_ptr(s.ptr, s.ai);
                  end else begin
                     // no acknowledge: stay off the line until the next start
                     n.bus  = ST_IDLE;
                     n.ptr  = next_ptr(s.ptr, s.ai);
                  end
               end else if (scl_fall && s.mack) begin
                  n.mack    = 1'b0;
                  n.bus     = ST_RDATA;
                  n.bit_cnt = 4'h0;
                  n.shift   = rdata;
                  n.sda_oe  = ~rdata[7];
               end
            end
            default: begin
               n.bus    = ST_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end

      // pin drive from selectors; the pin is read back whatever it is set to
      for (int i = 0; i < NUM_PINS; i++) begin
         code        = s.sel[i / PINS_PER_SEL][(i % PINS_PER_SEL) * 2 +: 2];
         n.pin_oe[i] = drive_low(code, blink_active);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset releases every line
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= STATE_RESET;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two blink channels
   for (genvar ch = 0; ch < NUM_BLINK; ch++) begin : g_blink
      lgec_blink_channel u_blink (
         .mclk    (mclk),
         .rst_n   (rst_n),
         .tick    (s.tick),
         .restart (s.restart[ch]),
         .cfg     (s.blink[ch]),
         .active  (blink_active[ch])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // open-drain outputs only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe  = s.sda_oe;
   assign pin_out = '0;
   assign pin_oe  = s.pin_oe;

endmodule : lgec_expander

/* dv/lgec_chk.sv */
`timescale 1ns/10ps
module lgec_chk
   import lgec_pkg::*;
(
   input wire logic                mclk,      // system clock
   input wire logic                reset_n,   // reset pin, low active
   input wire logic                supply_ok, // power-on detector
   input wire logic                scl_in,    // serial clock level
   input wire logic                sda_in,    // serial data level
   input wire logic                sda_out,   // data drive value
   input wire logic                sda_oe,    // data pulled low
   input wire logic [NUM_PINS-1:0] pin_out,   // pin drive values
   input wire logic [NUM_PINS-1:0] pin_oe     // pins pulled low
);
   wire         rst_n = reset_n & supply_ok;
   logic        scl_q;
   logic        sda_q;
   logic [3:0]  falls;
   logic [15:0] gap;
   logic [15:0] pin_q;

   // clock falls since start; clocks since a pin change seen on an idle clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         falls <= 4'h0;
         gap   <= 16'h0000;
         pin_q <= 16'h0000;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         pin_q <= pin_oe;
         if (scl_q && scl_in && sda_q && !sda_in) falls <= 4'h0;
         else if (scl_q && !scl_in && falls != 4'hF) falls <= falls + 4'h1;
         // bus writes land while the clock is low, so only blink steps reset this
         if (pin_oe != pin_q && scl_in) gap <= 16'h0000;
         else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_rel;
      pin_oe == '0 && !sda_oe;
   endsequence
   property p_pin_rst;
      @(posedge mclk) disable iff (!supply_ok) !reset_n |-> s_rel;
   endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("outputs driven during pin reset");
   property p_por;
      @(posedge mclk) disable iff (!reset_n) !supply_ok |-> s_rel;
   endproperty
   a_por: assert property (p_por) else $error("outputs driven with supply low");
   property p_release;
      @(posedge mclk) disable iff (!rst_n) $rose(rst_n) |-> s_rel[*3];
   endproperty
   a_release: assert property (p_release) else $error("outputs not idle after reset");
   property p_od;
      @(posedge mclk) disable iff (!rst_n) pin_out == '0 && sda_out == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("drive value not low");
   property p_sda_chg;
      @(posedge mclk) disable iff (!rst_n) $changed(sda_oe) |-> !scl_in;
   endproperty
   a_sda_chg: assert property (p_sda_chg) else $error("data moved with clock high");
   property p_ack8;
      @(posedge mclk) disable iff (!rst_n) $rose(sda_oe) |-> falls >= 4'h8;
   endproperty
   a_ack8: assert property (p_ack8) else $error("data pulled before eight bits");
   property p_ack_hold;
      @(posedge mclk) disable iff (!rst_n) $rose(sda_oe) |-> sda_oe[*3];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("data pull too short");
   property p_blink_gap;
      // gap is seen one clock before its own clear, so one step apart reads as one clock short
      @(posedge mclk) disable iff (!rst_n) $changed(pin_oe) && scl_in |-> gap >= 16'(TICK_CYCLES - 1);
   endproperty
   a_blink_gap: assert property (p_blink_gap) else $error("blink change off the step grid");
endmodule : lgec_chk

bind lgec_expander lgec_chk u_chk (.mclk(mclk), .reset_n(reset_n), .supply_ok(supply_ok), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pin_out(pin_out), .pin_oe(pin_oe));

/* dv/lgec_i2c_master.sv */
`timescale 1ns/10ps
module lgec_i2c_master
   import lgec_pkg::*;
(
   input  wire logic mclk,   // system clock
   input  wire logic sda_oe, // device pulls data low
   output logic      scl,    // serial clock level
   output logic      sda     // data wire level
);
   logic sda_m;

   // wire with pull-up: low if either side pulls
   assign sda = sda_m & ~sda_oe;

   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // four clocks a phase keeps well above the two clock minimum
   task automatic hp;
      repeat (4) @(negedge mclk);
   endtask : hp

   task automatic bit_io(input logic b, output logic s);
      sda_m = b;
      hp();
      scl = 1'b1;
      hp();
      s = sda;
      scl = 1'b0;
      hp();
   endtask : bit_io

   task automatic start;
      sda_m = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_m = 1'b0;
      hp();
      scl = 1'b0;
      hp();
   endtask : start

   task automatic stop;
      sda_m = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_m = 1'b1;
      hp();
   endtask : stop

   // one byte out (send FFh to read) plus the ninth bit
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic s);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(a, s);
   endtask : xfer
endmodule : lgec_i2c_master

/* dv/tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; $display("BAD %0t %h vs %h", $time, (a), (e)); end end
module tb_top;
   import lgec_pkg::*;
   localparam int STEP = TICK_CYCLES;       // clocks per duty step
   logic        mclk, reset_n, supply_ok, scl, sda, sda_out, sda_oe, r;
   logic [2:0]  asel;
   logic [7:0]  q;
   logic [15:0] pin_lvl, pin_in, pin_out, pin_oe;
   logic [7:0]  dflt[$] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
   int          err_count, check_count;

   // external pull-ups give pin_lvl unless the device pulls low
   assign pin_in = pin_lvl & ~pin_oe;

   lgec_expander DUT (.mclk(mclk), .reset_n(reset_n), .supply_ok(supply_ok), .addr_select_bit0(asel[0]),
      .addr_select_bit1(asel[1]), .addr_select_bit2(asel[2]), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   lgec_i2c_master m (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (err_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task automatic wr(input logic [7:0] c, input logic [7:0] d[$]);
      d.push_front(c);
      m.start();
      m.xfer({ADDR_FIXED, asel, 1'b0}, 1'b1, q, r);
      `CHK(r, 1'b0)
      foreach (d[i]) begin
         m.xfer(d[i], 1'b1, q, r);
         `CHK(r, 1'b0)
      end
      m.stop();
   endtask : wr

   // the last byte is refused so the device lets go of the wire
   task automatic rd(input logic [7:0] c, input logic [7:0] e[$]);
      m.start();
      m.xfer({ADDR_FIXED, asel, 1'b0}, 1'b1, q, r);
      m.xfer(c, 1'b1, q, r);
      m.start();
      m.xfer({ADDR_FIXED, asel, 1'b1}, 1'b1, q, r);
      foreach (e[i]) begin
         m.xfer(8'hFF, i == e.size() - 1, q, r);
         `CHK(q, e[i])
      end
      m.stop();
   endtask : rd

   // tick phase is free running, so allow one step of slack
   task automatic low_time(input int b, input int cyc);
      int n;
      n = 0;
      while (pin_oe[b] === 1'b1 && n < 9000) begin
         @(negedge mclk);
         n++;
      end
      `CHK(n > cyc - 600 && n < cyc + 520, 1'b1)
   endtask : low_time

   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      close_out();
   end

   initial begin
      {reset_n, supply_ok, asel, pin_lvl} = {2'b01, 3'h0, 16'hA5C3};
      repeat (6) @(negedge mclk);
      reset_n = 1'b1;
      repeat (2) @(negedge mclk);
      rd(8'h12, dflt);
      wr(8'h06, '{8'h55});
      `CHK(pin_oe, 16'h000F)
      rd(8'h10, '{8'hC0, 8'hA5});
      wr(8'h19, '{8'h00, 8'h11, 8'h22, 8'h01});
      rd(8'h02, '{8'h01});
      `CHK(pin_oe, 16'h000F)
      asel = 3'h5;
      m.start();
      m.xfer(8'hC0, 1'b1, q, r);
      `CHK(r, 1'b1)
      m.stop();
      wr(8'h12, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h55, 8'hAA, 8'hFF, 8'h00});
      wr(8'h03, '{8'h03});
      `CHK(pin_oe, 16'h00FF)
      low_time(4, 3 * 2 * STEP);
      wr(8'h05, '{8'h02});
      `CHK(pin_oe, 16'h0F0F)
      low_time(8, 2 * 1 * STEP);
      // pin reset first, then supply drop
      for (int k = 0; k < 2; k++) begin
         {reset_n, supply_ok} = k ? 2'b10 : 2'b01;
         @(negedge mclk);
         `CHK({pin_oe, sda_oe}, 17'h00000)
         repeat (3) @(negedge mclk);
         {reset_n, supply_ok} = 2'b11;
         repeat (2) @(negedge mclk);
         rd(8'h12, dflt);
      end
      close_out();
   end
endmodule : tb_top
